/* bench/sys_reset_model.sv */
// Behavioural system reset logic fed by the watchdog reset pin
`timescale 1ns/100ps
`default_nettype none

module sys_reset_model
(
    input  wire logic ref_clk,
    input  wire logic ext_nrst,
    input  wire logic reset_out_n,
    output var  logic nrst
);
    // Pin low or external reset holds the system in reset
    initial nrst = 1'b0;
    always @(posedge ref_clk)
        nrst <= ext_nrst & reset_out_n;
endmodule : sys_reset_model

`default_nettype wire

/* bench/tb_watchdog_reset_timer.sv */
// Self-checking bench for the watchdog reset timer
`timescale 1ns/100ps
`default_nettype none

module tb_watchdog_reset_timer;
    import wdg_pkg::*;
    localparam int P = 16;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d;} row_t;
    typedef struct {logic [7:0] v; logic h; logic o; int s; logic [7:0] ev;} case_t;

    logic       ref_clk   = 1'b0;
    logic       ext_nrst  = 1'b0;
    logic       nrst;
    logic       por_n     = 1'b0;
    logic       hw        = 1'b0;
    logic       halt      = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic [7:0] rdata;
    logic [7:0] rdata_bare;
    logic       reset_out_n;
    logic       irq;
    int         num_errors = 0;
    int         cmp_count  = 0;

    // Register map walk: reads carry the expected value in d
    row_t rows [14] = '{'{1'b0, 8'h2a, 8'h7f}, '{1'b0, 8'h2b, 8'h00}, '{1'b0, 8'h2c, 8'h00},
                        '{1'b0, 8'h2e, 8'h00}, '{1'b1, 8'h10, 8'hff}, '{1'b0, 8'h10, 8'h00},
                        '{1'b0, 8'h2d, 8'h00}, '{1'b1, 8'h2e, 8'h07}, '{1'b0, 8'h2e, 8'h07},
                        '{1'b1, 8'h2a, 8'h45}, '{1'b0, 8'h2a, 8'h45}, '{1'b1, 8'h2a, 8'hc5},
                        '{1'b1, 8'h2a, 8'h45}, '{1'b0, 8'h2a, 8'hc5}};
    // Timeouts C0h, FFh, soft reset, armed halt, hw option halt and timeout
    case_t cases [6] = '{'{8'hc0, 1'b0, 1'b0, 1, 8'h01}, '{8'hff, 1'b0, 1'b0, 64, 8'h01},
                         '{8'h80, 1'b0, 1'b0, 0, 8'h02}, '{8'hff, 1'b1, 1'b0, 0, 8'h04},
                         '{8'h00, 1'b1, 1'b1, 0, 8'h04}, '{8'h41, 1'b0, 1'b1, 2, 8'h01}};

    watchdog_reset_timer #(.PRESCALE(P)) uut
    (
        .ref_clk            (ref_clk),
        .nrst               (nrst),
        .por_n              (por_n),
        .hw_watchdog_option (hw),
        .halt_exec          (halt),
        .addr               (addr),
        .wdata              (wdata),
        .wr                 (wr),
        .rd                 (rd),
        .rdata              (rdata),
        .reset_out_n        (reset_out_n),
        .irq                (irq)
    );

    // Variant without the detector: status must read zero
    watchdog_reset_timer #(.PRESCALE(P), .HAS_LOW_VOLTAGE_DETECTOR(1'b0)) uut_bare
    (
        .ref_clk            (ref_clk),
        .nrst               (nrst),
        .por_n              (por_n),
        .hw_watchdog_option (hw),
        .halt_exec          (halt),
        .addr               (addr),
        .wdata              (wdata),
        .wr                 (wr),
        .rd                 (rd),
        .rdata              (rdata_bare),
        .reset_out_n        (),
        .irq                ()
    );

    sys_reset_model prm
    (
        .ref_clk     (ref_clk),
        .ext_nrst    (ext_nrst),
        .reset_out_n (reset_out_n),
        .nrst        (nrst)
    );

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Bus, compare and report tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: byte got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk_byte(rdata, e);
    endtask : rd_chk

    task automatic halt_pulse;
        @(posedge ref_clk);
        halt <= 1'b1;
        @(posedge ref_clk);
        halt <= 1'b0;
    endtask : halt_pulse

    // Counts low cycles of the pin, then lets system reset settle
    task automatic pulse_chk;
        int n;
        n = 0;
        while (reset_out_n === 1'b0 && n < 100)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk_byte(8'(n), 8'(RESET_PULSE_CYCLES));
        repeat (3) @(posedge ref_clk);
    endtask : pulse_chk

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask : end_test

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        ext_nrst <= 1'b1;
        por_n <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr_reg(rows[i].a, rows[i].d);
            else
                rd_chk(rows[i].a, rows[i].d);
        end
        end_test("register map");
        foreach (cases[i])
        begin
            chk_bit(reset_out_n, 1'b1);
            hw <= cases[i].o;
            if (cases[i].v !== 8'h00)
                wr_reg(8'h2a, cases[i].v);
            if (cases[i].h)
                halt_pulse();
            if (cases[i].s > 0)
            begin
                repeat (cases[i].s * P - 1) @(posedge ref_clk);
                #1 chk_bit(reset_out_n, 1'b1);
                @(posedge ref_clk);
            end
            #1 chk_bit(reset_out_n, 1'b0);
            pulse_chk();
            hw <= 1'b0;
            rd_chk(8'h2a, CONTROL_RESET);
            rd_chk(8'h2b, 8'h01);
            chk_byte(rdata_bare, 8'h00);
            rd_chk(8'h2c, cases[i].ev);
            chk_bit(irq, 1'b1);
            wr_reg(8'h2d, 8'h07);
            wr_reg(8'h2b, 8'h00);
            rd_chk(8'h2b, 8'h00);
            chk_bit(irq, 1'b0);
            end_test("reset source");
        end
        halt_pulse();
        repeat (3) @(posedge ref_clk);
        #1 chk_bit(reset_out_n, 1'b1);
        end_test("halt disarmed");
        wr_reg(8'h2a, 8'h80);
        #1 pulse_chk();
        por_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        por_n <= 1'b1;
        rd_chk(8'h2b, 8'h00);
        rd_chk(8'h2c, 8'h00);
        chk_bit(irq, 1'b0);
        end_test("power reset");
        finish_test();
    end

    initial
    begin
        #(CLK_PERIOD_NS * 5000);
        num_errors++;
        $display("CHECK FAILED at %0t: run did not complete", $time);
        finish_test();
    end
endmodule : tb_watchdog_reset_timer

`default_nettype wire

/* logic/watchdog_reset_timer.sv */
// Software-refreshed watchdog that forces a system reset pulse
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module watchdog_reset_timer
#(
    parameter int         PRESCALE                 = wdg_pkg::PRESCALE_CYCLES,
    parameter logic       HAS_LOW_VOLTAGE_DETECTOR = 1'b1
)
(
    input  wire logic     ref_clk,
    input  wire logic     nrst,
    input  wire logic     por_n,
    input  wire logic     hw_watchdog_option,
    input  wire logic     halt_exec,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic     wr,
    input  wire logic     rd,
    output var  logic [7:0] rdata,
    output var  logic     reset_out_n,
    output wire logic     irq
);
    import wdg_pkg::*;

    // ------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------
    logic                      arm_bit;
    logic [6:0]                countdown;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic                      watchdog_reset_flag;
    logic [PULSE_WIDTH-1:0]    pulse_left;
    logic [EVENT_WIDTH-1:0]    ev_status;
    logic [EVENT_WIDTH-1:0]    ev_enable;

    logic                      ctrl_wr;
    logic                      tick;
    logic                      armed;
    logic                      fire_timeout;
    logic                      fire_soft;
    logic                      fire_halt;
    logic                      fire;
    logic [EVENT_WIDTH-1:0]    next_events;

    assign ctrl_wr = wr && (addr == CONTROL_OFFSET);
    assign tick    = (prescale == PRESCALE_WIDTH'(PRESCALE - 1));
    assign armed   = arm_bit || hw_watchdog_option;

    // Reset requests, ignored while a pulse is already running
    assign fire_timeout = nrst && reset_out_n && armed && tick && !ctrl_wr
                          && (countdown == ROLL_FROM);
    assign fire_soft    = nrst && reset_out_n && ctrl_wr
                          && (armed || wdata[ARM_BIT_POS])
                          && !wdata[COUNTER_TOP_POS];
    assign fire_halt    = nrst && reset_out_n && armed && halt_exec;
    assign fire         = fire_timeout || fire_soft || fire_halt;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || ctrl_wr || tick)
            prescale <= '0;
        else
            prescale <= prescale + PRESCALE_WIDTH'(1);
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            arm_bit   <= CONTROL_RESET[ARM_BIT_POS];
            countdown <= CONTROL_RESET[6:0];
        end
        else if (ctrl_wr)
        begin
            arm_bit   <= arm_bit || wdata[ARM_BIT_POS];
            countdown <= wdata[6:0];
        end
        else if (tick)
            countdown <= countdown - COUNT_STEP;
    end

    // ------------------------------------------------------------
    // Reset pulse; only power reset cuts it short
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
        begin
            reset_out_n <= 1'b1;
            pulse_left  <= '0;
        end
        else if (fire)
        begin
            reset_out_n <= 1'b0;
            pulse_left  <= PULSE_WIDTH'(RESET_PULSE_CYCLES - 1);
        end
        else if (pulse_left != '0)
            pulse_left  <= pulse_left - PULSE_WIDTH'(1);
        else
            reset_out_n <= 1'b1;
    end

    // ------------------------------------------------------------
    // Watchdog reset flag, survives system reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
            watchdog_reset_flag <= STATUS_RESET[FLAG_POS];
        else if (fire && HAS_LOW_VOLTAGE_DETECTOR)
            watchdog_reset_flag <= 1'b1;
        else if (wr && (addr == STATUS_OFFSET) && !wdata[FLAG_POS])
            watchdog_reset_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt status and enable
    // ------------------------------------------------------------
    always_comb
    begin
        next_events                = '0;
        next_events[EV_TIMEOUT]    = fire_timeout;
        next_events[EV_SOFT_RESET] = fire_soft;
        next_events[EV_HALT_RESET] = fire_halt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
            ev_status <= EVENT_RESET;
        else if (wr && (addr == EVENT_CLEAR_OFFSET))
            ev_status <= (ev_status & ~wdata[EVENT_WIDTH-1:0]) | next_events;
        else
            ev_status <= ev_status | next_events;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!por_n)
            ev_enable <= EVENT_RESET;
        else if (wr && (addr == EVENT_ENABLE_OFFSET))
            ev_enable <= wdata[EVENT_WIDTH-1:0];
    end

    assign irq = |(ev_status & ev_enable);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                CONTROL_OFFSET:      rdata <= {arm_bit, countdown};
                STATUS_OFFSET:       rdata <= {7'h00, watchdog_reset_flag
                                               && HAS_LOW_VOLTAGE_DETECTOR};
                EVENT_STATUS_OFFSET: rdata <= {5'h00, ev_status};
                EVENT_ENABLE_OFFSET: rdata <= {5'h00, ev_enable};
                default:             rdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    int unsigned since_load;
    int unsigned load_steps;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst || ctrl_wr)
            since_load <= 0;
        else
            since_load <= since_load + 1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            load_steps <= 0;
        else if (ctrl_wr)
            load_steps <= 32'(wdata[5:0]) + 1;
    end

    a_count_step: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && !ctrl_wr) |=> (countdown == $past(countdown) - COUNT_STEP)
                               && (prescale == '0))
        else $error("countdown did not step on prescaler wrap");

    a_timeout_span: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fire_timeout && load_steps != 0)
            |-> (since_load == load_steps * 32'(PRESCALE) - 1))
        else $error("timeout came at the wrong cycle count");

    a_roll_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reset_out_n && armed && tick && !ctrl_wr && countdown == 7'h40)
            |=> !reset_out_n)
        else $error("armed roll from 40h did not start reset");

    a_pulse_len: assert property (@(posedge ref_clk) disable iff (!por_n)
        $fell(reset_out_n) |-> (!reset_out_n)[*8] ##17 !reset_out_n ##1 reset_out_n)
        else $error("reset pulse length is not 25 cycles");

    a_disarm_reset: assert property (@(posedge ref_clk) disable iff (!por_n)
        !nrst |=> !arm_bit && countdown == 7'h7f)
        else $error("control not at 7Fh after reset");

    a_arm_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
        (arm_bit && nrst) |=> arm_bit)
        else $error("arm bit cleared without reset");

    a_soft_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reset_out_n && ctrl_wr && wdata[7] && !wdata[6]) |=> !reset_out_n)
        else $error("software reset write did not reset");

    a_halt_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reset_out_n && halt_exec && (arm_bit || hw_watchdog_option))
            |=> !reset_out_n)
        else $error("halt while armed did not reset");

    a_hw_option: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reset_out_n && hw_watchdog_option && !arm_bit && tick && !ctrl_wr
         && countdown == 7'h40) |=> !reset_out_n)
        else $error("hardware option did not force reset");

    a_flag_set: assert property (@(posedge ref_clk) disable iff (!por_n)
        (fire && HAS_LOW_VOLTAGE_DETECTOR) |=> watchdog_reset_flag ##1 watchdog_reset_flag
            || $past(wr))
        else $error("watchdog reset flag not set");

    a_status_unused: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd && addr == 8'h2b && !HAS_LOW_VOLTAGE_DETECTOR) |=> rdata == 8'h00)
        else $error("status read nonzero without detector");

    a_write_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl_wr |=> countdown == $past(wdata[6:0]) && prescale == '0)
        else $error("control write did not load countdown");

    // ------------------------------------------------------------
    // Flag, events and disarmed state
    // ------------------------------------------------------------
    a_flag_survive: assert property (@(posedge ref_clk) disable iff (!por_n)
        (!nrst && watchdog_reset_flag && !(wr && addr == STATUS_OFFSET))
            |=> watchdog_reset_flag)
        else $error("watchdog reset flag lost during system reset");

    a_flag_clear: assert property (@(posedge ref_clk) disable iff (!por_n)
        (wr && addr == STATUS_OFFSET && !wdata[FLAG_POS] && !fire)
            |=> !watchdog_reset_flag)
        else $error("status write did not clear the flag");

    a_status_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd && addr == STATUS_OFFSET && HAS_LOW_VOLTAGE_DETECTOR)
            |=> rdata[FLAG_POS] == $past(watchdog_reset_flag) && rdata[7:1] == 7'h00)
        else $error("status read does not show the flag");

    a_halt_disarmed: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reset_out_n && halt_exec && !arm_bit && !hw_watchdog_option && !ctrl_wr)
            |=> reset_out_n)
        else $error("halt while disarmed started a reset");

    a_disarmed_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reset_out_n && !arm_bit && !hw_watchdog_option && !ctrl_wr)
            |=> reset_out_n)
        else $error("disarmed watchdog started a reset");

    a_event_timeout: assert property (@(posedge ref_clk) disable iff (!por_n)
        fire_timeout |=> ev_status[EV_TIMEOUT])
        else $error("timeout event not recorded");

    a_event_soft: assert property (@(posedge ref_clk) disable iff (!por_n)
        fire_soft |=> ev_status[EV_SOFT_RESET])
        else $error("software reset event not recorded");

    a_event_halt: assert property (@(posedge ref_clk) disable iff (!por_n)
        fire_halt |=> ev_status[EV_HALT_RESET])
        else $error("halt reset event not recorded");

endmodule : watchdog_reset_timer

`default_nettype wire

/* logic/wdg_pkg.sv */
// Constants shared by the watchdog reset timer
package wdg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_OFFSET      = 8'h2a;
    localparam logic [7:0] STATUS_OFFSET       = 8'h2b;
    localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h2c;
    localparam logic [7:0] EVENT_CLEAR_OFFSET  = 8'h2d;
    localparam logic [7:0] EVENT_ENABLE_OFFSET = 8'h2e;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         ARM_BIT_POS       = 7;
    localparam int         COUNTER_TOP_POS   = 6;
    localparam int         FLAG_POS          = 0;
    localparam logic [7:0] CONTROL_RESET     = 8'h7f;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [6:0] ROLL_FROM         = 7'h40;
    localparam logic [6:0] COUNT_STEP        = 7'h01;

    // Event bits of the interrupt registers
    localparam int         EVENT_WIDTH       = 3;
    localparam int         EV_TIMEOUT        = 0;
    localparam int         EV_SOFT_RESET     = 1;
    localparam int         EV_HALT_RESET     = 2;
    localparam logic [2:0] EVENT_RESET       = 3'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS      = 20;
    localparam int         PRESCALE_CYCLES    = 12288;
    localparam int         PRESCALE_WIDTH     = 14;
    localparam int         RESET_PULSE_NS     = 500;
    localparam int         RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
    localparam int         PULSE_WIDTH        = 5;

    // Timeout figures at an 8 MHz CPU clock
    localparam int         REF_CPU_KHZ        = 8000;
    localparam int         TIMEOUT_MAX_US     = 98304;
    localparam int         TIMEOUT_MIN_US     = 1536;
    localparam int         TIMEOUT_MAX_STEPS  = TIMEOUT_MAX_US * REF_CPU_KHZ / 1000
                                                / PRESCALE_CYCLES;
    localparam int         TIMEOUT_MIN_STEPS  = TIMEOUT_MIN_US * REF_CPU_KHZ / 1000
                                                / PRESCALE_CYCLES;

endpackage : wdg_pkg
